// [hw/lpre_cfg.svh]
// constants for the led pwm ramp executor
`ifndef LPRE_CFG_SVH
`define LPRE_CFG_SVH

// register addresses
`define LPRE_ADDR_CTRL1      8'h06
`define LPRE_ADDR_CTRL2      8'h07
`define LPRE_ADDR_CTRL3      8'h08
`define LPRE_ADDR_VAR_A      8'h3b
`define LPRE_ADDR_VAR_D      8'h3c
`define LPRE_ADDR_TEST       8'h42

// control register fields and reset values
`define LPRE_CTRL_LOG_BIT    7
`define LPRE_CTRL_DSRC_BIT   6
`define LPRE_CTRL_RESET      8'h00
`define LPRE_VAR_RESET       8'h00
`define LPRE_PWM_RESET       8'h00
`define LPRE_PWM_MAX         8'hff

// numeric form fields
`define LPRE_NUM_PRESCALE    14
`define LPRE_NUM_STEP_HI     13
`define LPRE_NUM_STEP_LO     9
`define LPRE_NUM_SIGN        8
`define LPRE_NUM_COUNT_HI    7
`define LPRE_NUM_COUNT_LO    0

// variable form fields
`define LPRE_VAR_PRESCALE    5
`define LPRE_VAR_SIGN        4
`define LPRE_VAR_STEP_HI     3
`define LPRE_VAR_STEP_LO     2
`define LPRE_VAR_COUNT_HI    1
`define LPRE_VAR_COUNT_LO    0

// variable selector codes
`define LPRE_SEL_A           2'h0
`define LPRE_SEL_B           2'h1
`define LPRE_SEL_C           2'h2
`define LPRE_SEL_D           2'h3

// prescale: master clock 32768 hz divided by 16 or 512
`define LPRE_MASTER_HZ       32768
`define LPRE_DIV_FAST        16
`define LPRE_DIV_SLOW        512

`endif

// [hw/lpre_pkg.sv]
// types of the led pwm ramp executor
`include "lpre_cfg.svh"

package lpre_pkg;

  typedef logic [15:0] lpre_instr_t;
  typedef logic [7:0]  lpre_byte_t;
  typedef logic [4:0]  lpre_step_t;

  typedef enum logic {
    LPRE_IDLE,
    LPRE_RUN
  } lpre_state_t;

  typedef struct packed {
    lpre_state_t st;
    logic        prescale;
    logic        down;
    logic        fast;
    lpre_step_t  step_time;
    lpre_step_t  step_cnt;
    lpre_byte_t  remain;
    lpre_byte_t  pwm;
    lpre_byte_t  pwm_out;
    lpre_byte_t  var_a;
    lpre_byte_t  var_b;
    lpre_byte_t  var_c;
    lpre_byte_t  var_d;
    lpre_byte_t  ctrl;
    lpre_byte_t  rdata;
    logic        busy;
    logic        done;
  } lpre_regs_t;

  typedef struct packed {
    logic [8:0] cnt;
    logic       pulse;
  } lpre_timer_t;

endpackage : lpre_pkg

// [hw/lpre_step_timer.sv]
// prescale cycle timer driven by the 32768 hz master tick
`timescale 1ns/1ps
`default_nettype none
`include "lpre_cfg.svh"

module lpre_step_timer (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clock_enable,
  input  wire logic restart,
  input  wire logic prescale_sel,
  input  wire logic master_tick,
  output logic      cycle_pulse
);
  import lpre_pkg::*;

  localparam logic [8:0] LAST_FAST = 9'(`LPRE_DIV_FAST - 1);
  localparam logic [8:0] LAST_SLOW = 9'(`LPRE_DIV_SLOW - 1);

  lpre_timer_t t;
  lpre_timer_t next_t;
  logic [8:0]  last;

  // [R3] divide by 16 or 512
  always_comb begin
    next_t = t;
    last = prescale_sel ? LAST_SLOW : LAST_FAST;
    next_t.pulse = 1'b0;
    if (restart) begin
      next_t.cnt = 9'h000;
    end else if (master_tick) begin
      if (t.cnt == last) begin
        next_t.cnt = 9'h000;
        next_t.pulse = 1'b1;
      end else begin
        next_t.cnt = t.cnt + 9'h001;
      end
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t <= '0;
    end else if (clock_enable) begin
      t <= next_t;
    end
  end

  assign cycle_pulse = t.pulse;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  prescale_div_a : assert property ( // [R3]
    (clock_enable && master_tick && !restart && t.cnt == last)
      |=> (t.pulse || !$past(clock_enable)))
    else $error("prescale cycle pulse missing at divider end");

endmodule : lpre_step_timer
`default_nettype wire

// [hw/lpre_ramp_executor.sv]
// ramp instruction executor of one program execution engine
//
// Notes on behaviour
// [R1] ramp starts at current pwm value, one unit per step, except zero cases
// [R2] numeric form: prescale from bit 14, step time from bits 13:9
// [R3] prescale 0 divides master clock by 16, prescale 1 by 512
// [R4] one step lasts step time times the prescale cycle
// [R5] zero step time does the whole change within one prescale cycle
// [R6] sign 0 raises the pwm value, sign 1 lowers it
// [R7] numeric form: bits 7:0 give the step count, up to 255
// [R8] pwm saturates at 0 or 255 but the ramp runs its full length
// [R9] zero count leaves pwm unchanged and waits one step duration
// [R10] variable form latches step time and count at start
// [R11] step time variable chosen by selector, only its five low bits
// [R12] count selector: 0 A, 1 B, 2 C, 3 global D
// [R13] program must load the step time variable with 1 to 31
// [R14] global D written at 0x3c, or taken from test result at 0x42
// [R15] variables A, B and C are written only by the load instruction
// [R16] only A of the locals is readable; D is readable and writable
// [R17] control bit selects logarithmic (1) or linear (0) curve
// [R18] after the last step the ramp retires, keeping the pwm value
`timescale 1ns/1ps
`default_nettype none
`include "lpre_cfg.svh"

module lpre_ramp_executor #(
  parameter int ENGINE_INDEX = 1
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                clock_enable,
  input  wire logic                master_tick,
  input  wire logic                start,
  input  wire logic                variable_form,
  input  wire lpre_pkg::lpre_instr_t instr,
  input  wire logic                pwm_load,
  input  wire lpre_pkg::lpre_byte_t pwm_load_value,
  input  wire logic                load_we,
  input  wire logic [1:0]          load_sel,
  input  wire lpre_pkg::lpre_byte_t load_value,
  input  wire lpre_pkg::lpre_byte_t led_test_value,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  input  wire lpre_pkg::lpre_byte_t reg_wdata,
  output lpre_pkg::lpre_byte_t     reg_rdata,
  output lpre_pkg::lpre_byte_t     pwm_out,
  output logic                     busy,
  output logic                     done
);
  import lpre_pkg::*;

  // ==========================================================
  // elaboration check
  // ==========================================================
  if (ENGINE_INDEX < 1 || ENGINE_INDEX > 3) begin : g_bad_engine
    $error("engine index must be 1, 2 or 3");
  end

  localparam logic [7:0] CTRL_ADDR =
    (ENGINE_INDEX == 1) ? `LPRE_ADDR_CTRL1 :
    (ENGINE_INDEX == 2) ? `LPRE_ADDR_CTRL2 : `LPRE_ADDR_CTRL3;

  // ==========================================================
  // functions
  // ==========================================================
  // saturating add or subtract of an amount to the pwm value
  function automatic lpre_byte_t sat_move(input lpre_byte_t v,
                                          input lpre_byte_t amt,
                                          input logic dn);
    logic [8:0] sum;
    sum = {1'b0, v} + {1'b0, amt};
    if (dn) begin
      sat_move = (amt > v) ? 8'h00 : 8'(v - amt);
    end else begin
      sat_move = sum[8] ? `LPRE_PWM_MAX : sum[7:0];
    end
  endfunction : sat_move

  // output curve: square law approximates the eye's log response
  function automatic lpre_byte_t curve(input lpre_byte_t v,
                                       input logic log_en);
    logic [15:0] sq;
    sq = ({8'h00, v} * {8'h00, v}) + 16'h00ff;
    curve = log_en ? sq[15:8] : v;
  endfunction : curve

  // variable selected by a two bit code
  function automatic lpre_byte_t pick(input logic [1:0] sel,
                                      input lpre_regs_t r,
                                      input lpre_byte_t d);
    unique case (sel)
      `LPRE_SEL_A: pick = r.var_a;
      `LPRE_SEL_B: pick = r.var_b;
      `LPRE_SEL_C: pick = r.var_c;
      `LPRE_SEL_D: pick = d;
    endcase
  endfunction : pick

  // ==========================================================
  // reset release
  // ==========================================================
  logic rst_meta;
  logic rst_n;

  // two flops release the asynchronous reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // state
  // ==========================================================
  lpre_regs_t s;
  lpre_regs_t next_s;
  logic       cycle_pulse;
  logic       timer_restart;
  logic       start_prescale;
  lpre_byte_t var_d_eff;
  lpre_byte_t cnt_src;
  lpre_byte_t step_src;
  logic       step_end;
  lpre_byte_t remain_left;

  // [R3] prescale timer restarts with each ramp
  lpre_step_timer u_timer (
    .clock        (clock),
    .rst_n        (rst_n),
    .clock_enable (clock_enable),
    .restart      (timer_restart),
    .prescale_sel (timer_restart ? start_prescale : s.prescale),
    .master_tick  (master_tick),
    .cycle_pulse  (cycle_pulse)
  );

  // operand sources at start
  always_comb begin
    // [R14] global D from its register or from the test result
    var_d_eff = s.ctrl[`LPRE_CTRL_DSRC_BIT] ? led_test_value : s.var_d;
    start_prescale = variable_form ? instr[`LPRE_VAR_PRESCALE]
                                   : instr[`LPRE_NUM_PRESCALE];
    // [R11] step time variable, five low bits kept
    step_src = variable_form
      ? pick(instr[`LPRE_VAR_STEP_HI:`LPRE_VAR_STEP_LO], s, var_d_eff)
      : {3'h0, instr[`LPRE_NUM_STEP_HI:`LPRE_NUM_STEP_LO]};
    // [R12] step count variable
    cnt_src = variable_form
      ? pick(instr[`LPRE_VAR_COUNT_HI:`LPRE_VAR_COUNT_LO], s, var_d_eff)
      : instr[`LPRE_NUM_COUNT_HI:`LPRE_NUM_COUNT_LO];
    timer_restart = start && (s.st == LPRE_IDLE);
  end

  // next state
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    step_end = 1'b0;
    remain_left = 8'h00;

    // [R15] only the load instruction writes A, B and C
    if (load_we) begin
      unique case (load_sel)
        `LPRE_SEL_A: next_s.var_a = load_value;
        `LPRE_SEL_B: next_s.var_b = load_value;
        `LPRE_SEL_C: next_s.var_c = load_value;
        `LPRE_SEL_D: next_s.var_d = s.var_d;
      endcase
    end

    // register writes
    if (reg_we) begin
      // [R14] global D written at its address
      if (reg_addr == `LPRE_ADDR_VAR_D) begin
        next_s.var_d = reg_wdata;
      end
      // [R17] curve select lives in the engine control register
      if (reg_addr == CTRL_ADDR) begin
        next_s.ctrl = reg_wdata;
      end
    end

    // [R16] register reads, unmapped addresses answer zero
    if (reg_re) begin
      if (reg_addr == `LPRE_ADDR_VAR_D) begin
        next_s.rdata = s.var_d;
      end else if (reg_addr == `LPRE_ADDR_VAR_A) begin
        next_s.rdata = s.var_a;
      end else if (reg_addr == `LPRE_ADDR_TEST) begin
        next_s.rdata = led_test_value;
      end else if (reg_addr == CTRL_ADDR) begin
        next_s.ctrl = next_s.ctrl;
        next_s.rdata = s.ctrl;
      end else begin
        next_s.rdata = 8'h00;
      end
    end

    unique case (s.st)
      LPRE_IDLE: begin
        if (pwm_load) begin
          next_s.pwm = pwm_load_value;
        end
        if (start) begin
          // [R10] operands latched once, later writes do not matter
          next_s.st = LPRE_RUN;
          next_s.busy = 1'b1;
          // [R2] prescale and step time of the numeric or variable form
          next_s.prescale = start_prescale;
          next_s.step_time = step_src[4:0];
          // [R6] sign picks the direction
          next_s.down = variable_form ? instr[`LPRE_VAR_SIGN]
                                      : instr[`LPRE_NUM_SIGN];
          // [R7] step count
          next_s.remain = cnt_src;
          next_s.fast = (step_src[4:0] == 5'h00);
          next_s.step_cnt = 5'h00;
        end
      end
      LPRE_RUN: begin
        if (cycle_pulse) begin
          if (s.fast) begin
            // [R5] whole change inside one prescale cycle
            next_s.pwm = sat_move(s.pwm, s.remain, s.down);
            next_s.remain = 8'h00;
            step_end = 1'b1;
          end else if (s.step_cnt + 5'h01 == s.step_time) begin
            // [R4] step spans step_time prescale cycles
            next_s.step_cnt = 5'h00;
            step_end = 1'b1;
            if (s.remain != 8'h00) begin
              // [R1] one unit per step, [R8] held at the limits
              next_s.pwm = sat_move(s.pwm, 8'h01, s.down);
              remain_left = s.remain - 8'h01;
              next_s.remain = remain_left;
            end
          end else begin
            next_s.step_cnt = s.step_cnt + 5'h01;
          end
          // [R9] a zero count still waits one step, [R18] retire
          if (step_end && (s.fast || remain_left == 8'h00)) begin
            next_s.st = LPRE_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
        end
      end
    endcase

    // [R17] log or linear curve on the output
    next_s.pwm_out = curve(next_s.pwm, next_s.ctrl[`LPRE_CTRL_LOG_BIT]);
  end

  // state register, frozen while the enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: LPRE_IDLE, ctrl: `LPRE_CTRL_RESET,
             var_a: `LPRE_VAR_RESET, var_b: `LPRE_VAR_RESET,
             var_c: `LPRE_VAR_RESET, var_d: `LPRE_VAR_RESET,
             pwm: `LPRE_PWM_RESET, pwm_out: `LPRE_PWM_RESET,
             default: '0};
    end else if (clock_enable) begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign pwm_out = s.pwm_out;
  assign busy = s.busy;
  assign done = s.done;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence run_slow_s;
    s.st == LPRE_RUN && !s.fast && clock_enable;
  endsequence

  sequence num_start_s;
    s.st == LPRE_IDLE && start && !variable_form && clock_enable;
  endsequence

  step_one_a : assert property ( // [R1]
    run_slow_s |=> (s.pwm == $past(s.pwm) ||
                    s.pwm == 8'($past(s.pwm) + 8'h01) ||
                    s.pwm == 8'($past(s.pwm) - 8'h01)))
    else $error("ramp moved pwm by more than one unit");

  num_fields_a : assert property ( // [R2]
    num_start_s |=> (s.prescale == $past(instr[14]) &&
                     s.step_time == $past(instr[13:9])))
    else $error("numeric prescale or step time not captured");

  step_len_a : assert property ( // [R4]
    run_slow_s |-> s.step_cnt < s.step_time)
    else $error("step counter beyond step time");

  fast_whole_a : assert property ( // [R5]
    (s.st == LPRE_RUN && s.fast && cycle_pulse && clock_enable)
      |=> (s.st == LPRE_IDLE && s.done && s.remain == 8'h00))
    else $error("zero step time ramp not done in one cycle");

  dir_up_a : assert property ( // [R6]
    (s.st == LPRE_RUN && !s.down && clock_enable)
      |=> s.pwm >= $past(s.pwm))
    else $error("rising ramp lowered the pwm value");

  num_count_a : assert property ( // [R7]
    num_start_s |=> s.remain == $past(instr[7:0]))
    else $error("numeric step count not captured");

  sat_hold_a : assert property ( // [R8]
    (run_slow_s and (s.pwm == `LPRE_PWM_MAX && !s.down))
      |=> s.pwm == `LPRE_PWM_MAX)
    else $error("saturated pwm wrapped");

  wait_hold_a : assert property ( // [R9]
    (s.st == LPRE_RUN && s.remain == 8'h00 && clock_enable)
      |=> s.pwm == $past(s.pwm))
    else $error("zero count ramp changed pwm");

  var_latch_a : assert property ( // [R10]
    (s.st == LPRE_RUN && clock_enable && !cycle_pulse)
      |=> $stable(s.step_time) && $stable(s.down))
    else $error("running ramp operands changed");

  var_d_write_a : assert property ( // [R14]
    (reg_we && reg_addr == `LPRE_ADDR_VAR_D && clock_enable)
      |=> s.var_d == $past(reg_wdata))
    else $error("global variable write lost");

  curve_out_a : assert property ( // [R17]
    (clock_enable && !s.ctrl[`LPRE_CTRL_LOG_BIT] && !reg_we)
      |=> pwm_out == s.pwm)
    else $error("linear curve output differs from pwm");

  retire_a : assert property ( // [R18]
    done |-> (s.st == LPRE_IDLE && !busy))
    else $error("done while ramp still running");

endmodule : lpre_ramp_executor
`default_nettype wire

// [testbench/lpre_led_sink.sv]
// model of the led drivers fed by the engine pwm value
`timescale 1ns/1ps
`default_nettype none

module lpre_led_sink (
  input  wire logic       clock,
  input  wire logic [7:0] level,
  output logic [15:0]     change_count
);
  logic [7:0] last_level;

  initial change_count = 16'h0000;

  // ==========================================
  // driver side: count each new duty level seen
  always @(posedge clock) begin
    if (level !== last_level) begin
      change_count <= change_count + 16'h0001;
    end
    last_level <= level;
  end
endmodule : lpre_led_sink
`default_nettype wire

// [testbench/tb_led_pwm_ramp_executor.sv]
// self-checking bench of the ramp executor
`timescale 1ns/1ps
`default_nettype none
`include "lpre_cfg.svh"

module tb_led_pwm_ramp_executor;
  typedef struct { logic [7:0] pwm; int dur; } lpre_note_t;
  logic                 clock, resetn, start, variable_form, pwm_load;
  logic                 load_we, reg_we, reg_re, busy, done, rd_seen, log_on;
  logic [1:0]           load_sel;
  lpre_pkg::lpre_instr_t instr;
  lpre_pkg::lpre_byte_t pwm_load_value, load_value, led_test_value;
  lpre_pkg::lpre_byte_t reg_wdata, reg_rdata, pwm_out;
  logic [7:0]           reg_addr;
  logic [15:0]          change_count, c0;
  int                   n_errors, check_count, cyc, t0, cur, v, s;
  lpre_note_t           ramp_q[$], nt;
  logic [7:0]           rd_q[$];

  lpre_ramp_executor #(.ENGINE_INDEX(1)) dut_u (
    .clock(clock), .resetn(resetn), .clock_enable(1'b1),
    .master_tick(1'b1), .start(start), .variable_form(variable_form),
    .instr(instr), .pwm_load(pwm_load), .pwm_load_value(pwm_load_value),
    .load_we(load_we), .load_sel(load_sel), .load_value(load_value),
    .led_test_value(led_test_value), .reg_addr(reg_addr),
    .reg_we(reg_we), .reg_re(reg_re), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pwm_out(pwm_out), .busy(busy), .done(done));

  lpre_led_sink sink_u (.clock(clock), .level(pwm_out),
    .change_count(change_count));

  // ==========================================
  // clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================
  // monitor: compare results against the oldest notes
  always @(posedge clock) begin
    cyc++;
    if (start === 1'b1 && busy === 1'b0) t0 = cyc;
    if (rd_seen) check(reg_rdata, rd_q.pop_front());
    rd_seen <= (reg_re === 1'b1);
    if (done === 1'b1) begin
      if (ramp_q.size() == 0) begin
        check(16'h1, 16'h0);
      end else begin
        nt = ramp_q.pop_front();
        check(busy, 16'h0);
        check(pwm_out, nt.pwm);
        check(16'(cyc - t0 >= nt.dur && cyc - t0 <= nt.dur + 3), 1);
      end
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
    // let an edge pass so a following call never re-raises the strobe
    @(posedge clock);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    @(posedge clock);
  endtask : reg_rd

  task automatic ldv(input logic [1:0] sel, input logic [7:0] d);
    load_sel <= sel;
    load_value <= d;
    load_we <= 1'b1;
    @(posedge clock);
    load_we <= 1'b0;
    // let an edge pass so a following call never re-raises the strobe
    @(posedge clock);
  endtask : ldv

  task automatic setpwm(input int d);
    pwm_load_value <= 8'(d);
    pwm_load <= 1'b1;
    @(posedge clock);
    pwm_load <= 1'b0;
    cur = d;
    repeat (4) @(posedge clock);
  endtask : setpwm

  // launch one ramp, note its result, wait for its end
  task automatic ramp(input logic vf, input logic [15:0] ins, input int n,
                      input int st, input int ps, input int dn,
                      input int again);
    int i;
    int w;
    lpre_note_t e;
    w = (dn != 0) ? cur - n : cur + n;
    w = (w < 0) ? 0 : ((w > 255) ? 255 : w);
    e.pwm = log_on ? 8'((w * w + 255) >> 8) : 8'(w);
    e.dur = ((st == 0) ? 1 : ((n == 0) ? 1 : n) * st) *
            ((ps != 0) ? `LPRE_DIV_SLOW : `LPRE_DIV_FAST);
    cur = w;
    ramp_q.push_back(e);
    start <= 1'b1;
    variable_form <= vf;
    instr <= ins;
    @(posedge clock);
    start <= 1'b0;
    for (i = 0; i < 20000 && done !== 1'b1; i++) begin
      if (i == 1) check(busy, 16'h1);
      if (again != 0 && i == 3) begin
        start <= 1'b1;
        pwm_load <= 1'b1;
        pwm_load_value <= 8'h00;
      end
      if (again != 0 && i == 4) begin
        start <= 1'b0;
        pwm_load <= 1'b0;
      end
      @(posedge clock);
    end
    @(posedge clock);
  endtask : ramp

  task automatic rampn(input int ps, input int st, input int dn,
                       input int n, input int again);
    ramp(1'b0, {1'b0, 1'(ps), 5'(st), 1'(dn), 8'(n)}, n, st, ps, dn, again);
  endtask : rampn

  task automatic rampv(input int ss, input int cs, input int n, input int st);
    ramp(1'b1, {12'h000, 2'(ss), 2'(cs)}, n, st, 0, 0, 0);
  endtask : rampv

  // ==========================================
  // watchdog
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  // ==========================================
  // main sequence
  initial begin
    {start, variable_form, pwm_load, load_we, reg_we, reg_re} = '0;
    {instr, pwm_load_value, load_value, load_sel, reg_addr} = '0;
    {reg_wdata, rd_seen, log_on, cyc, t0} = '0;
    led_test_value = 8'h5a;
    resetn = 1'b0;
    void'($urandom(75));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    reg_rd(8'h3c, 8'h00);
    reg_rd(8'h06, 8'h00);
    check(pwm_out, 8'h00);
    $display("reset test done");
    // numeric ramp up, one change per step
    setpwm(140);
    c0 = change_count;
    rampn(0, 2, 0, 8, 0);
    check(change_count - c0, 16'd8);
    c0 = change_count;
    repeat (40) @(posedge clock);
    check(change_count, c0);
    v = $urandom_range(20, 230);
    setpwm(v);
    rampn(0, 1, 1, 5, 1);
    rampn(0, 0, 0, 5, 0);
    rampn(0, 3, 0, 0, 0);
    setpwm(253);
    rampn(0, 1, 0, 5, 0);
    setpwm(2);
    rampn(0, 1, 1, 4, 0);
    rampn(1, 1, 0, 1, 0);
    $display("numeric test done");
    reg_wr(8'h3c, 8'h02);
    reg_rd(8'h3c, 8'h02);
    reg_wr(8'h42, 8'hff);
    reg_rd(8'h42, 8'h5a);
    reg_rd(8'h50, 8'h00);
    // step variables keep low bits within 1 to 31
    ldv(2'h0, 8'h21);
    ldv(2'h1, 8'h42);
    ldv(2'h2, 8'h63);
    reg_rd(8'h3b, 8'h21);
    reg_wr(8'h3b, 8'h00);
    reg_rd(8'h3b, 8'h21);
    for (s = 0; s < 3; s++) rampv(s, 3, 2, s + 1);
    ldv(2'h0, 8'h01);
    ldv(2'h1, 8'h02);
    ldv(2'h2, 8'h03);
    for (s = 0; s < 4; s++) rampv(3, s, (s == 3) ? 2 : s + 1, 2);
    // writes during the ramp do not change the running ramp
    fork
      rampv(3, 0, 1, 2);
      begin
        repeat (3) @(posedge clock);
        reg_wr(8'h3c, 8'h14);
        ldv(2'h0, 8'h09);
      end
    join
    v = $urandom_range(1, 5);
    led_test_value <= 8'(v);
    reg_wr(8'h06, 8'h40);
    rampv(3, 0, 9, v);
    $display("variable test done");
    reg_wr(8'h06, 8'h80);
    reg_rd(8'h06, 8'h80);
    log_on = 1'b1;
    setpwm(127);
    rampn(0, 1, 0, 1, 0);
    log_on = 1'b0;
    reg_wr(8'h06, 8'h00);
    check(16'(ramp_q.size()), 16'h0);
    $display("curve test done");
    finish_test();
  end
endmodule : tb_led_pwm_ramp_executor
`default_nettype wire
